/* File: hw/qps_sequencer.sv */
`timescale 1ns/1ps
// Behaviour
// - Switch starts only with relay and qualified supply.
// - Relay rise: relay on, switch ignored 25.6ms.
// - Relay fall: switch off, relay off 3.2ms later.
// - Relay changes only while switch is off, except on undervoltage, which turns both off in the same cycle.
// - Undervoltage holds all switches and relays off.
// - Soft start sources gate until fully on.
// - Overcurrent past timeout latches off, discharges gate.
// - Retry restarts after duty-derived off time.
// - Power good needs low drop, no limit.
// - Sense at limit enters foldback current limit.
// - Triple limit sense applies fast gate pulldown.
// - Open detector arms 900ms after power good.
// - Common input enables open detection everywhere.
// - Open trip latches off and sets flag.
// - Relay driver polarity set by variant parameter.
// - Four independent ports share supply monitor.
// - Status select routes power good or open flag.
// - Without retry, latch holds until enable has fallen and the off time has passed.
// - Duty input picks 1, 2 or 4 percent.
// - Shared low fault output when any latched.
module qps_sequencer
    import qps_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int TO_TICKS = TO_DEFAULT_TICKS,
    parameter bit RELAY_ACTIVE_LOW = 1'b1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic supplyOk,
    input wire logic [qps_pkg::NUM_PORTS-1:0] switchEnable,
    input wire logic [qps_pkg::NUM_PORTS-1:0] relayEnableIn,
    input wire logic openDetectEnable,
    input wire logic statusSelect,
    input wire logic retryEnable,
    input wire logic dutyHigh,
    input wire logic dutyOpen,
    input wire logic [qps_pkg::NUM_PORTS-1:0] limitSenseHit,
    input wire logic [qps_pkg::NUM_PORTS-1:0] fastSenseHit,
    input wire logic [qps_pkg::NUM_PORTS-1:0] openSenseHit,
    input wire logic [qps_pkg::NUM_PORTS-1:0] dropOk,
    output logic [qps_pkg::NUM_PORTS-1:0] relayDriveOut,
    output logic [qps_pkg::NUM_PORTS-1:0] gateSource,
    output logic [qps_pkg::NUM_PORTS-1:0] gateDischarge,
    output logic [qps_pkg::NUM_PORTS-1:0] gateFastDischarge,
    output logic [qps_pkg::NUM_PORTS-1:0] foldbackActive,
    output logic [qps_pkg::NUM_PORTS-1:0] statusOut,
    output logic faultN
);
    import qps_pkg::*;

    // ****************************************************************
    // Parameter checks and derived constants
    // ****************************************************************
    if (TICK_DIV < 2 || TICK_DIV >= (1 << DIV_W)) begin : gen_bad_div
        $error("TICK_DIV out of range");
    end
    if (TO_TICKS < 1 || TO_TICKS * OFF_MULT_MAX >= (1 << CNT_W) - 1) begin : gen_bad_to
        $error("TO_TICKS out of range");
    end

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
    localparam logic [CNT_W-1:0] TO_LIMIT = CNT_W'(TO_TICKS);
    localparam logic [NUM_PORTS-1:0] RELAY_OFF_LEVEL = {NUM_PORTS{RELAY_ACTIVE_LOW}};

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        qps_port_state_t [NUM_PORTS-1:0] st;
        logic [NUM_PORTS-1:0][CNT_W-1:0] cnt;
        logic [NUM_PORTS-1:0] lastLimit;
        logic [NUM_PORTS-1:0] enLowSeen;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [QUAL_W-1:0] qual;
        logic qualified;
        logic [NUM_PORTS-1:0] relay;
        logic [NUM_PORTS-1:0] gate;
        logic [NUM_PORTS-1:0] pull;
        logic [NUM_PORTS-1:0] fast;
        logic [NUM_PORTS-1:0] fold;
        logic [NUM_PORTS-1:0] stat;
        logic faultN;
    } qps_state_t;

    qps_state_t state;
    qps_state_t next_state;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] pinSync;
    logic supplyS;
    logic [NUM_PORTS-1:0] enS;
    logic [NUM_PORTS-1:0] relayS;
    logic detectS;
    logic selS;
    logic retryS;
    logic dutyHighS;
    logic dutyOpenS;
    logic [NUM_PORTS-1:0] limS;
    logic [NUM_PORTS-1:0] fastS;
    logic [NUM_PORTS-1:0] lowS;
    logic [NUM_PORTS-1:0] dropS;

    // Every pin is asynchronous, so all of them pass two stages.
    assign pinRaw = {supplyOk, switchEnable, relayEnableIn, openDetectEnable, statusSelect,
                     retryEnable, dutyHigh, dutyOpen, limitSenseHit, fastSenseHit,
                     openSenseHit, dropOk};
    assign {supplyS, enS, relayS, detectS, selS, retryS, dutyHighS, dutyOpenS,
            limS, fastS, lowS, dropS} = pinSync;

    qps_sync #(
        .WIDTH(PIN_W)
    ) pinSyncInst (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn(pinRaw),
        .syncOut(pinSync)
    );

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Count one tick, saturating so a long wait never wraps.
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic t);
        return (t && v != '1) ? v + 1'b1 : v;
    endfunction

    // Off time after an overcurrent latch, from the three-level duty input.
    function automatic logic [CNT_W-1:0] offTime(input logic hi, input logic open);
        logic [6:0] m;
        m = open ? OFF_MULT_4PCT : (hi ? OFF_MULT_2PCT : OFF_MULT_1PCT);
        return CNT_W'(TO_LIMIT * CNT_W'(m));
    endfunction

    // A switch is driven only in soft start or fully on.
    function automatic logic gateOn(input qps_port_state_t s);
        return (s == PS_START) || (s == PS_ON);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    logic [CNT_W-1:0] offLimit;
    logic limChange;
    logic [CNT_W-1:0] counted;

    // Timebase, supply qualification and the four port sequencers.
    always_comb begin
        next_state = state;
        offLimit = offTime(dutyHighS, dutyOpenS);
        limChange = 1'b0;
        counted = '0;
        // One shared timebase paces every millisecond delay.
        next_state.tick = 1'b0;
        if (state.div == DIV_LAST) begin
            next_state.div = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.div = state.div + 1'b1;
        end
        // The supply must stay good for longer than the turn-on delay.
        if (!supplyS) begin
            next_state.qual = '0;
        end else if (state.tick && state.qual != QUAL_TICKS) begin
            next_state.qual = state.qual + 1'b1;
        end
        next_state.qualified = (next_state.qual == QUAL_TICKS);
        // Each port runs on its own state and counter, sharing the supply monitor.
        for (int i = 0; i < NUM_PORTS; i++) begin
            limChange = limS[i] != state.lastLimit[i];
            counted = bump(state.cnt[i], state.tick);
            next_state.lastLimit[i] = limS[i];
            case (state.st[i])
                PS_OFF: begin
                    next_state.cnt[i] = '0;
                    if (relayS[i]) begin
                        next_state.st[i] = PS_RLY_WAIT;
                    end
                end
                PS_RLY_WAIT: begin
                    next_state.cnt[i] = counted;
                    if (!relayS[i]) begin
                        next_state.st[i] = PS_RLY_OFF;
                        next_state.cnt[i] = '0;
                    end else if (state.cnt[i] > RELAY_ON_TICKS) begin
                        next_state.st[i] = PS_READY;
                    end
                end
                PS_READY: begin
                    next_state.cnt[i] = '0;
                    if (!relayS[i]) begin
                        next_state.st[i] = PS_RLY_OFF;
                    end else if (enS[i] && state.qualified) begin
                        next_state.st[i] = PS_START;
                    end
                end
                PS_START, PS_ON: begin
                    if (!relayS[i]) begin
                        next_state.st[i] = PS_RLY_OFF;
                        next_state.cnt[i] = '0;
                    end else if (!enS[i]) begin
                        next_state.st[i] = PS_READY;
                        next_state.cnt[i] = '0;
                    end else if (limS[i]) begin
                        // Time the stay in current limit.
                        next_state.cnt[i] = limChange ? '0 : counted;
                        if (!limChange && state.cnt[i] > TO_LIMIT) begin
                            next_state.st[i] = PS_OC_LATCH;
                            next_state.cnt[i] = '0;
                            next_state.enLowSeen[i] = 1'b0;
                        end
                    end else if (state.st[i] == PS_START) begin
                        next_state.cnt[i] = '0;
                        if (dropS[i]) begin
                            next_state.st[i] = PS_ON;
                        end
                    end else if (limChange || !dropS[i]) begin
                        next_state.cnt[i] = '0;
                    end else begin
                        // Power good holds: count towards arming the detector.
                        next_state.cnt[i] = counted;
                        if (state.cnt[i] > ARM_TICKS && detectS && lowS[i]) begin
                            next_state.st[i] = PS_OPEN_LATCH;
                            next_state.cnt[i] = '0;
                        end
                    end
                end
                PS_RLY_OFF: begin
                    next_state.cnt[i] = counted;
                    if (state.cnt[i] > RELAY_OFF_TICKS) begin
                        next_state.st[i] = PS_OFF;
                    end
                end
                PS_OC_LATCH: begin
                    next_state.cnt[i] = counted;
                    if (!enS[i]) begin
                        next_state.enLowSeen[i] = 1'b1;
                    end
                    if (!relayS[i]) begin
                        next_state.st[i] = PS_RLY_OFF;
                        next_state.cnt[i] = '0;
                    end else if (state.cnt[i] > offLimit) begin
                        if (retryS) begin
                            next_state.st[i] = PS_START;
                            next_state.cnt[i] = '0;
                        end else if (state.enLowSeen[i]) begin
                            next_state.st[i] = PS_READY;
                            next_state.cnt[i] = '0;
                        end
                    end
                end
                PS_OPEN_LATCH: begin
                    next_state.cnt[i] = '0;
                    if (!relayS[i]) begin
                        next_state.st[i] = PS_RLY_OFF;
                    end else if (!enS[i]) begin
                        next_state.st[i] = PS_READY;
                    end
                end
                default: begin
                    next_state.st[i] = PS_OFF;
                    next_state.cnt[i] = '0;
                end
            endcase
            // Undervoltage lockout resets the port outright.
            if (!supplyS) begin
                next_state.st[i] = PS_OFF;
                next_state.cnt[i] = '0;
            end
        end
        // Registered outputs follow the new port states; the fast pulldown follows the current state.
        for (int i = 0; i < NUM_PORTS; i++) begin
            next_state.relay[i] = (next_state.st[i] != PS_OFF) ^ RELAY_ACTIVE_LOW;
            next_state.gate[i] = gateOn(next_state.st[i]);
            next_state.pull[i] = !gateOn(next_state.st[i]);
            next_state.fast[i] = fastS[i] && gateOn(state.st[i]);
            next_state.fold[i] = limS[i] && gateOn(next_state.st[i]);
            // Power good when on with low drop and no limit, else the open flag.
            next_state.stat[i] = selS
                ? (next_state.st[i] == PS_ON && dropS[i] && !limS[i])
                : (next_state.st[i] == PS_OPEN_LATCH);
        end
        next_state.faultN = supplyS;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (next_state.st[i] == PS_OC_LATCH || next_state.st[i] == PS_OPEN_LATCH) begin
                next_state.faultN = 1'b0;
            end
        end
        if (sys_rst) begin
            next_state = '0;
            next_state.relay = RELAY_OFF_LEVEL;
            next_state.pull = '1;
            next_state.faultN = 1'b1;
        end
    end

    // Register the whole state record.
    always_ff @(posedge clock) begin
        state <= next_state;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output is a field of the registered state.
    assign relayDriveOut = state.relay;
    assign gateSource = state.gate;
    assign gateDischarge = state.pull;
    assign gateFastDischarge = state.fast;
    assign foldbackActive = state.fold;
    assign statusOut = state.stat;
    assign faultN = state.faultN;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic [NUM_PORTS-1:0] relayOn;
    // Relay state as a logical on level, whatever the variant polarity.
    assign relayOn = state.relay ^ RELAY_OFF_LEVEL;
    AST_UVLO_OFF: assert property (
        !supplyS |=> (state.gate == '0) && (relayOn == '0) && !state.faultN)
        else $error("Port left on during undervoltage.");
    AST_GATE_RELAY: assert property (
        (state.gate & ~relayOn) == '0)
        else $error("Switch driven while its relay is off.");
    AST_RLY_FALL: assert property (
        $fell(relayS[0]) |=> !state.gate[0])
        else $error("Switch not cut on relay enable fall.");
    AST_RLY_HOLD: assert property (
        $rose(state.st[0] == PS_RLY_OFF) |-> relayOn[0] [*8])
        else $error("Relay released before its off delay.");
    AST_WAIT_HOLD: assert property (
        state.st[0] == PS_RLY_WAIT |-> !state.gate[0] && relayOn[0])
        else $error("Switch on during relay settle delay.");
    AST_SUPPLY_QUAL: assert property (
        state.st[0] == PS_READY && !state.qualified |=> state.st[0] != PS_START)
        else $error("Start without a qualified supply.");
    AST_POWER_GOOD: assert property (
        state.stat[0] && $past(selS) |-> $past(dropS[0]) && !$past(limS[0]))
        else $error("Power good shown with drop or limit.");
    AST_OPEN_FLAG: assert property (
        state.stat[0] && !$past(selS) |-> state.st[0] == PS_OPEN_LATCH && !state.gate[0])
        else $error("Open flag without open latch.");
    AST_FAULT: assert property (
        state.st[0] == PS_OC_LATCH || state.st[0] == PS_OPEN_LATCH |-> !faultN)
        else $error("Fault output high while latched.");
    AST_FAST: assert property (
        fastS[0] && state.gate[0] && supplyS |=> state.fast[0])
        else $error("Fast pulldown missing.");
    AST_RETRY_HOLD: assert property (
        state.st[0] == PS_OC_LATCH && !retryS |=> state.st[0] != PS_START)
        else $error("Restart from latch without retry.");
    COV_PORT_ON: cover property (state.st[0] == PS_START ##1 state.st[0] == PS_ON);
    COV_OC_LATCH: cover property (state.st[0] == PS_OC_LATCH);
    COV_OPEN_LATCH: cover property (state.st[0] == PS_OPEN_LATCH);
    COV_RETRY: cover property (state.st[0] == PS_OC_LATCH ##1 state.st[0] == PS_START);
endmodule

/* File: include/qps_pkg.sv */
// ****************************************************************
// Shared constants and types of the quad port power sequencer.
// ****************************************************************
package qps_pkg;
    localparam int NUM_PORTS = 4;
    // Clock rate and the period of the internal delay timebase.
    localparam int CLK_MHZ = 50;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int DIV_W = 13;
    // Documented delays in microseconds.
    localparam int RELAY_ON_US = 25600;
    localparam int RELAY_OFF_US = 3200;
    localparam int ARM_US = 900000;
    localparam int TO_DEFAULT_US = 6400;
    // Delays in timebase ticks; least times round up.
    localparam int CNT_W = 18;
    localparam int QUAL_W = 9;
    localparam logic [QUAL_W-1:0] QUAL_TICKS =
        QUAL_W'((RELAY_ON_US + TICK_US - 1) / TICK_US + 1);
    localparam logic [CNT_W-1:0] RELAY_ON_TICKS =
        CNT_W'((RELAY_ON_US + TICK_US - 1) / TICK_US);
    localparam logic [CNT_W-1:0] RELAY_OFF_TICKS =
        CNT_W'((RELAY_OFF_US + TICK_US - 1) / TICK_US);
    localparam logic [CNT_W-1:0] ARM_TICKS =
        CNT_W'((ARM_US + TICK_US - 1) / TICK_US);
    localparam int TO_DEFAULT_TICKS = TO_DEFAULT_US / TICK_US;
    // Off time as a multiple of the overcurrent timeout per duty.
    localparam logic [6:0] OFF_MULT_1PCT = 7'h63;
    localparam logic [6:0] OFF_MULT_2PCT = 7'h31;
    localparam logic [6:0] OFF_MULT_4PCT = 7'h18;
    localparam int OFF_MULT_MAX = 99;
    // Width of the bundle of pin inputs passed through the synchroniser.
    localparam int PIN_W = 30;

    typedef enum logic [2:0] {
        PS_OFF = 3'b000,
        PS_RLY_WAIT = 3'b001,
        PS_READY = 3'b010,
        PS_START = 3'b011,
        PS_ON = 3'b100,
        PS_RLY_OFF = 3'b101,
        PS_OC_LATCH = 3'b110,
        PS_OPEN_LATCH = 3'b111
    } qps_port_state_t;
endpackage

/* File: hw/qps_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser for a bundle of pin levels.
// ****************************************************************
module qps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } qps_sync_state_t;

    qps_sync_state_t state;
    qps_sync_state_t next_state;

    // The first stage feeds only the second stage.
    always_comb begin
        next_state.stage1 = asyncIn;
        next_state.stage2 = state.stage1;
        if (sys_rst) begin
            next_state = '0;
        end
    end

    // Register both stages.
    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign syncOut = state.stage2;
endmodule

/* File: verification/qps_far_side.sv */
`timescale 1ns/1ps
// ****************************************************************
// Far side: power switches, relays and sense comparators.
// ****************************************************************
module qps_far_side
    import qps_pkg::*;
(
    input wire logic clock,
    input wire logic [qps_pkg::NUM_PORTS-1:0] relayDriveOut,
    input wire logic [qps_pkg::NUM_PORTS-1:0] gateSource,
    input wire logic [qps_pkg::NUM_PORTS-1:0] overload,
    input wire logic [qps_pkg::NUM_PORTS-1:0] openLoad,
    input wire logic [qps_pkg::NUM_PORTS-1:0] spike,
    output logic [qps_pkg::NUM_PORTS-1:0] dropOk,
    output logic [qps_pkg::NUM_PORTS-1:0] limitSenseHit,
    output logic [qps_pkg::NUM_PORTS-1:0] fastSenseHit,
    output logic [qps_pkg::NUM_PORTS-1:0] openSenseHit
);
    import qps_pkg::*;
    logic [3:0] ramp [NUM_PORTS];
    logic [NUM_PORTS-1:0] conducting;
    // Current flows only with the gate charged and the relay closed.
    assign conducting = gateSource & ~relayDriveOut;
    assign limitSenseHit = conducting & overload;
    assign fastSenseHit = conducting & spike;
    assign openSenseHit = ~conducting | openLoad;
    // The gate ramps slowly, so the switch drop is low only after a delay.
    always_ff @(posedge clock) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (!gateSource[p]) begin
                ramp[p] <= 4'h0;
            end else if (ramp[p] != 4'hF) begin
                ramp[p] <= ramp[p] + 4'h1;
            end
            dropOk[p] <= gateSource[p] && ramp[p] == 4'hF;
        end
    end
endmodule

/* File: verification/qps_testbench.sv */
`timescale 1ns/1ps
module testbench
    import qps_pkg::*;
;
    localparam int TD = 4;
    localparam int TOT = 2;
    logic clock, sys_rst, supplyOk, openDetectEnable, statusSelect;
    logic retryEnable, dutyHigh, dutyOpen, faultN;
    logic [3:0] switchEnable, relayEnableIn, limitSenseHit, fastSenseHit, openSenseHit;
    logic [3:0] dropOk, relayDriveOut, gateSource, gateDischarge, gateFastDischarge;
    logic [3:0] foldbackActive, statusOut, overload, openLoad, spike;
    int err_count, n_tests, cycles, n;
    int mult [3] = '{99, 49, 24};
    qps_sequencer #(.TICK_DIV(TD), .TO_TICKS(TOT)) u_qps_sequencer (.clock(clock),
        .sys_rst(sys_rst), .supplyOk(supplyOk), .switchEnable(switchEnable),
        .relayEnableIn(relayEnableIn), .openDetectEnable(openDetectEnable),
        .statusSelect(statusSelect), .retryEnable(retryEnable), .dutyHigh(dutyHigh),
        .dutyOpen(dutyOpen), .limitSenseHit(limitSenseHit), .fastSenseHit(fastSenseHit),
        .openSenseHit(openSenseHit), .dropOk(dropOk), .relayDriveOut(relayDriveOut),
        .gateSource(gateSource), .gateDischarge(gateDischarge),
        .gateFastDischarge(gateFastDischarge), .foldbackActive(foldbackActive),
        .statusOut(statusOut), .faultN(faultN));
    qps_far_side u_qps_far_side (.clock(clock), .relayDriveOut(relayDriveOut),
        .gateSource(gateSource), .overload(overload), .openLoad(openLoad), .spike(spike),
        .dropOk(dropOk), .limitSenseHit(limitSenseHit), .fastSenseHit(fastSenseHit),
        .openSenseHit(openSenseHit));
    // ****************************************************************
    // Clock, timeout and checking helpers.
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // A hung run counts as a mismatch and ends in the report.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chkRange(input string name, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    function automatic logic pick(input int sel, input int p);
        case (sel)
            0: return gateSource[p];
            1: return relayDriveOut[p];
            2: return faultN;
            default: return statusOut[p];
        endcase
    endfunction
    // Counts falling edges until the chosen output reaches a level.
    task automatic waitFor(input int sel, input int p, input logic lvl, input int lim,
                           output int cnt);
        cnt = 0;
        while (pick(sel, p) !== lvl && cnt < lim) begin
            @(negedge clock);
            cnt++;
        end
    endtask
    task automatic idle(input int ticks);
        repeat (ticks * TD) @(negedge clock);
    endtask
    // ****************************************************************
    // Main sequence; inputs change on the falling edge.
    // ****************************************************************
    initial begin
        {supplyOk, openDetectEnable, retryEnable, dutyHigh, dutyOpen} = 5'h00;
        {switchEnable, relayEnableIn, overload, openLoad, spike} = 20'h00000;
        statusSelect = 1'b1;
        sys_rst = 1'b1;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        chk("resetRelay", 4'hF, relayDriveOut);
        chk("resetGate", 4'h0, gateSource);
        chk("resetDischarge", 4'hF, gateDischarge);
        chk("resetStatus", 4'h0, statusOut);
        chk("resetFault", 4'h1, {3'h0, faultN});
        relayEnableIn = 4'h1;
        idle(300);
        chk("uvloRelay", 4'hF, relayDriveOut);
        relayEnableIn = 4'h0;
        idle(2);
        supplyOk = 1'b1;
        idle(300);
        relayEnableIn = 4'h1;
        switchEnable = 4'h1;
        waitFor(1, 0, 1'b0, 8, n);
        chkRange("relayOnDelay", 1, 4, n);
        waitFor(0, 0, 1'b1, 300 * TD, n);
        chkRange("switchDelay", 256 * TD - 1, 257 * TD + 4, n);
        chk("gateOthers", 4'h1, gateSource);
        chk("dischargeOff", 4'hE, gateDischarge);
        waitFor(3, 0, 1'b1, 40, n);
        chk("powerGood", 4'h1, statusOut);
        overload = 4'h1;
        repeat (6) @(negedge clock);
        chk("foldback", 4'h1, foldbackActive);
        chk("goodInLimit", 4'h0, statusOut);
        waitFor(0, 0, 1'b0, (TOT + 2) * TD + 8, n);
        chk("ocLatchGate", 4'hF, gateDischarge);
        waitFor(2, 0, 1'b0, 4, n);
        chk("faultLow", 4'h0, {3'h0, faultN});
        overload = 4'h0;
        idle(250);
        chk("latchHolds", 4'h0, gateSource);
        switchEnable = 4'h0;
        idle(2);
        switchEnable = 4'h1;
        waitFor(0, 0, 1'b1, 20, n);
        chk("latchCleared", 4'h1, gateSource);
        chk("faultHigh", 4'h1, {3'h0, faultN});
        spike = 4'h1;
        repeat (6) @(negedge clock);
        chk("fastPull", 4'h1, gateFastDischarge);
        spike = 4'h0;
        retryEnable = 1'b1;
        overload = 4'h1;
        for (int d = 0; d < 3; d++) begin
            dutyHigh = (d == 1);
            dutyOpen = (d == 2);
            waitFor(0, 0, 1'b0, 40, n);
            waitFor(0, 0, 1'b1, 200 * TOT * TD, n);
            chkRange("offTime", TOT * mult[d] * TD - 2, (TOT * mult[d] + 1) * TD + 8, n);
        end
        overload = 4'h0;
        retryEnable = 1'b0;
        waitFor(3, 0, 1'b1, 40, n);
        openDetectEnable = 1'b1;
        statusSelect = 1'b0;
        openLoad = 4'h1;
        idle(8900);
        chk("notArmed", 4'h1, gateSource);
        waitFor(0, 0, 1'b0, 200 * TD, n);
        chk("openTrip", 4'h0, gateSource);
        repeat (4) @(negedge clock);
        chk("openFlag", 4'h1, statusOut);
        chk("openFault", 4'h0, {3'h0, faultN});
        openLoad = 4'h0;
        switchEnable = 4'h0;
        idle(2);
        switchEnable = 4'h1;
        waitFor(0, 0, 1'b1, 20, n);
        chk("openCleared", 4'h1, gateSource);
        relayEnableIn = 4'h0;
        waitFor(0, 0, 1'b0, 5, n);
        chkRange("switchOffDelay", 1, 4, n);
        waitFor(1, 0, 1'b1, 40 * TD, n);
        chkRange("relayOffDelay", 32 * TD - 1, 33 * TD + 4, n);
        relayEnableIn = 4'h2;
        switchEnable = 4'h2;
        idle(5);
        chk("port1Relay", 4'hD, relayDriveOut);
        supplyOk = 1'b0;
        repeat (6) @(negedge clock);
        chk("uvloDrop", 4'hF, relayDriveOut);
        chk("uvloGate", 4'h0, gateSource);
        summarize();
    end
endmodule
